// file: dv/core_model.sv
// Behavioural processor core: completes instructions, raises interrupts
`default_nettype none

module core_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Requests from the bench
    input wire logic step,
    input wire logic irq,
    // Core handshake
    input wire logic cpu_clock_enable,
    output logic instr_done,
    output logic int_request
);
    timeunit 1ns;
    timeprecision 1ps;

    // Halted core completes nothing; done is registered one cycle after each enabled step
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            instr_done <= 1'h0;
        else
            instr_done <= step && cpu_clock_enable;
    end

    // Bench interrupt held as a level, not gated by any enable
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            int_request <= 1'h0;
        else
            int_request <= irq;
    end
endmodule // core_model

`default_nettype wire

// file: dv/pwr_mode_props.sv
// Port checks for the power mode controller
`default_nettype none

module pwr_mode_props
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_write,
    input wire logic sfr_read,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Core side and modes
    input wire logic int_request,
    input wire logic cpu_clock_enable,
    input wire logic wake_resume,
    input wire logic boot_start,
    input wire logic periph_enable,
    input wire logic int_enable,
    input wire logic [8:0] gpio_in,
    input wire logic supply_off,
    input wire logic [5:0] general_flags,
    input wire logic [5:0] mode_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_idle_halt: assert property (mode_state == 6'h04 |->
        !cpu_clock_enable && periph_enable && int_enable)
        else $error("core not halted in idle");
    a_idle_wake: assert property (mode_state == 6'h04 &&
        int_request && clk_en |=> mode_state == 6'h02 && wake_resume)
        else $error("interrupt did not end idle");
    a_stop_gate: assert property (mode_state == 6'h08 |->
        !cpu_clock_enable && !periph_enable && !int_enable)
        else $error("stop left something running");
    a_stop_hold: assert property (mode_state == 6'h08 |=>
        mode_state == 6'h08) else $error("stop left without reset");
    a_sel_zero: assert property (sfr_rdata[1:0] == 2'h0)
        else $error("select bits read nonzero");
    a_read_flags: assert property (clk_en && sfr_read && sfr_hit &&
        !sfr_write |=> sfr_rdata == {general_flags, 2'h0})
        else $error("read data not the flags");
    a_flag_write: assert property (clk_en && sfr_write && sfr_hit |=>
        {general_flags, 2'h0} == ($past(sfr_wdata) & 8'hFC))
        else $error("flags not written");
    a_boot_seq: assert property (mode_state == 6'h01 && clk_en |->
        boot_start && !cpu_clock_enable ##1 mode_state == 6'h02)
        else $error("boot sequence wrong");
    a_shut_supply: assert property (mode_state == 6'h10 ||
        mode_state == 6'h20 |-> supply_off && !cpu_clock_enable)
        else $error("supply on in shutdown");
    a_shut_wake: assert property (not ((clk_en &&
        mode_state == 6'h10 && !(&gpio_in)) [*8]))
        else $error("low pin did not wake");

    c_idle_exit: cover property (mode_state == 6'h04 ##1 mode_state == 6'h02);
    c_stop: cover property (mode_state == 6'h08);
    c_wake: cover property (mode_state == 6'h20);
endmodule // pwr_mode_props

bind cpu_power_mode_control pwr_mode_props pwr_mode_props_i (
    .clk(clk), .reset(reset), .clk_en(clk_en), .sfr_wdata(sfr_wdata),
    .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .int_request(int_request),
    .cpu_clock_enable(cpu_clock_enable), .wake_resume(wake_resume),
    .boot_start(boot_start), .periph_enable(periph_enable),
    .int_enable(int_enable), .gpio_in(gpio_in), .supply_off(supply_off),
    .general_flags(general_flags), .mode_state(mode_state));

`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the power mode controller
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, clk_en, sfr_write, sfr_read, sfr_hit, instr_done;
    logic int_request, cpu_clock_enable, wake_resume, boot_start, step, irq;
    logic periph_enable, int_enable, shutdown_request, supply_off;
    logic wake_reset_request;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [8:0] gpio_in;
    logic [5:0] general_flags, mode_state;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    int i;

    cpu_power_mode_control cpu_power_mode_control_i (.clk(clk),
        .reset(reset), .clk_en(clk_en), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_read(sfr_read),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .instr_done(instr_done),
        .int_request(int_request), .cpu_clock_enable(cpu_clock_enable),
        .wake_resume(wake_resume), .boot_start(boot_start),
        .periph_enable(periph_enable), .int_enable(int_enable),
        .shutdown_request(shutdown_request), .gpio_in(gpio_in),
        .supply_off(supply_off), .wake_reset_request(wake_reset_request),
        .general_flags(general_flags), .mode_state(mode_state));
    core_model core_model_i (.clk(clk), .reset(reset), .step(step),
        .irq(irq), .cpu_clock_enable(cpu_clock_enable),
        .instr_done(instr_done), .int_request(int_request));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_write <= 1'b1;
        @(posedge clk);
        sfr_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        sfr_read <= 1'b1;
        @(posedge clk);
        sfr_read <= 1'b0;
        #1;
        chk({1'b0, sfr_rdata}, {1'b0, exp});
    endtask

    task automatic run_op;
        @(posedge clk);
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
    endtask

    task automatic wait_mode(input logic [5:0] m);
        #1;
        for (i = 0; i < 12 && mode_state !== m; i++) #10;
        chk({3'h0, mode_state}, {3'h0, m});
    endtask

    task automatic do_reset;
        @(posedge clk);
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({8'h00, boot_start}, 9'h001);
        @(posedge clk);
        reset <= 1'b0;
    endtask

    task automatic t_regs;
        rd(8'h87, 8'h00);
        chk({8'h00, sfr_hit}, 9'h001);
        wr(8'h87, 8'hFC);
        rd(8'h87, 8'hFC);
        wr(8'h86, 8'h00);
        rd(8'h87, 8'hFC);
        rd(8'h86, 8'h00);
        chk({8'h00, sfr_hit}, 9'h000);
    endtask

    task automatic t_freeze;
        @(posedge clk);
        clk_en <= 1'h0;
        wr(8'h87, 8'h00);
        #1;
        chk({3'h0, general_flags}, 9'h03F);
        @(posedge clk);
        clk_en <= 1'h1;
    endtask

    task automatic t_idle;
        wr(8'h87, 8'hA9);
        #1;
        chk({3'h0, general_flags}, 9'h02A);
        rd(8'h87, 8'hA8);
        wait_mode(6'h02);
        run_op;
        wait_mode(6'h04);
        chk({7'h00, cpu_clock_enable, periph_enable}, 9'h001);
        rd(8'h87, 8'hA8);
        @(posedge clk);
        irq <= 1'b1;
        #1;
        for (i = 0; i < 8 && wake_resume !== 1'b1; i++) #10;
        chk({8'h00, wake_resume}, 9'h001);
        chk({3'h0, mode_state}, 9'h002);
        @(posedge clk);
        irq <= 1'b0;
        run_op;
        repeat (3) @(posedge clk);
        #1;
        chk({3'h0, mode_state}, 9'h002);
    endtask

    task automatic t_idle_reset;
        wr(8'h87, 8'hFD);
        run_op;
        wait_mode(6'h04);
        do_reset;
        wait_mode(6'h02);
        rd(8'h87, 8'h00);
    endtask

    task automatic t_stop;
        wr(8'h87, 8'h06);
        run_op;
        wait_mode(6'h08);
        chk({7'h00, periph_enable, int_enable}, 9'h000);
        @(posedge clk);
        irq <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk({3'h0, mode_state}, 9'h008);
        @(posedge clk);
        irq <= 1'h0;
        do_reset;
        wait_mode(6'h02);
    endtask

    task automatic t_shut;
        @(posedge clk);
        shutdown_request <= 1'b1;
        @(posedge clk);
        shutdown_request <= 1'b0;
        wait_mode(6'h10);
        chk({8'h00, supply_off}, 9'h001);
        @(posedge clk);
        gpio_in <= 9'h1F7;
        #1;
        for (i = 0; i < 12 && wake_reset_request !== 1'b1; i++) #10;
        chk({8'h00, wake_reset_request}, 9'h001);
        wait_mode(6'h20);
        @(posedge clk);
        gpio_in <= 9'h1FF;
        do_reset;
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            end_sim();
        end
    end

    initial
    begin
        reset <= 1'b1;
        clk_en <= 1'b1;
        sfr_addr <= 8'h00;
        sfr_wdata <= 8'h00;
        sfr_write <= 1'b0;
        sfr_read <= 1'b0;
        shutdown_request <= 1'b0;
        gpio_in <= 9'h1FF;
        step <= 1'b0;
        irq <= 1'b0;
        do_reset;
        t_regs;
        t_freeze;
        t_idle;
        t_idle_reset;
        t_stop;
        t_shut;
        end_sim();
    end
endmodule // testbench

`default_nettype wire

// file: src/cpu_power_mode_control.sv
// Processor idle, stop and shutdown mode controller
// Function
// - Idle bit set halts the processor when the writing instruction completes.
// - Idle only gates the processor; state, memories, peripherals keep running.
// - Enabled interrupt in idle clears idle bit and resumes the processor.
// - Reset during idle restarts through the normal boot sequence.
// - Stop bit set halts processor, peripherals, interrupts and timers.
// - Only reset leaves stop; interrupts are ignored there.
// - System clock keeps running during stop.
// - Idle and stop select bits always read back as zero.
// - Bits 7 to 2 are six plain read/write general flags.
// - Shutdown mode wakes when a GPIO input is pulled to ground.
`default_nettype none

`include "pwr_cfg.svh"

module cpu_power_mode_control
(
    // Clock, reset and clock enable
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_write,
    input wire logic sfr_read,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Processor core handshake
    input wire logic instr_done,
    input wire logic int_request,
    output logic cpu_clock_enable,
    output logic wake_resume,
    output logic boot_start,
    // Peripheral and interrupt gating
    output logic periph_enable,
    output logic int_enable,
    // Shutdown and wake pins
    input wire logic shutdown_request,
    input wire logic [`PWR_GPIO_COUNT-1:0] gpio_in,
    output logic supply_off,
    output logic wake_reset_request,
    // Flag and state view
    output logic [`PWR_FLAGS_WIDTH-1:0] general_flags,
    output logic [5:0] mode_state
);

    pwr_pkg::pwr_state_t state;
    pwr_pkg::pwr_state_t next_state;
    logic idle_select;
    logic stop_select;
    logic idle_clear;
    logic int_wake;
    logic pin_low;
    logic take_idle;
    logic take_stop;
    logic [`PWR_GPIO_COUNT-1:0] gpio_level;

    // ------------------------------------------------------------------
    // Register and pin synchroniser
    // ------------------------------------------------------------------
    pwr_reg u_reg
    (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata),
        .sfr_write(sfr_write),
        .sfr_read(sfr_read),
        .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit),
        .idle_clear(idle_clear),
        .idle_select(idle_select),
        .stop_select(stop_select),
        .general_flags(general_flags)
    );

    pwr_sync u_sync
    (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .pin_in(gpio_in),
        .pin_level(gpio_level)
    );

    // ------------------------------------------------------------------
    // Wake conditions
    // ------------------------------------------------------------------
    assign int_wake = (state == pwr_pkg::st_idle) && int_request;
    assign idle_clear = int_wake;
    assign pin_low = (gpio_level != `PWR_GPIO_IDLE);

    // ------------------------------------------------------------------
    // Mode entry once the writing instruction completes
    // ------------------------------------------------------------------
    assign take_stop = instr_done && stop_select;
    assign take_idle = instr_done && idle_select && !stop_select;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            pwr_pkg::st_boot:
            begin
                next_state = pwr_pkg::st_run;
            end
            pwr_pkg::st_run:
            begin
                if (shutdown_request)
                begin
                    next_state = pwr_pkg::st_shut;
                end
                else if (take_stop)
                begin
                    next_state = pwr_pkg::st_stop;
                end
                else if (take_idle)
                begin
                    next_state = pwr_pkg::st_idle;
                end
            end
            pwr_pkg::st_idle:
            begin
                if (int_request)
                begin
                    next_state = pwr_pkg::st_run;
                end
            end
            pwr_pkg::st_stop:
            begin
                next_state = pwr_pkg::st_stop;
            end
            pwr_pkg::st_shut:
            begin
                if (pin_low)
                begin
                    next_state = pwr_pkg::st_wake;
                end
            end
            pwr_pkg::st_wake:
            begin
                next_state = pwr_pkg::st_wake;
            end
            default:
            begin
                next_state = pwr_pkg::st_boot;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register, reset always restarts from boot
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state <= pwr_pkg::st_boot;
        end
        else if (clk_en)
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Resume and wake pulses
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wake_resume <= 1'h0;
        end
        else if (clk_en)
        begin
            wake_resume <= int_wake;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wake_reset_request <= 1'h0;
        end
        else if (clk_en)
        begin
            wake_reset_request <= (state == pwr_pkg::st_shut) && pin_low;
        end
    end

    // ------------------------------------------------------------------
    // Processor gating
    // ------------------------------------------------------------------
    always_comb
    begin
        boot_start = 1'h0;
        cpu_clock_enable = 1'h0;
        case (state)
            pwr_pkg::st_boot:
            begin
                boot_start = 1'h1;
                cpu_clock_enable = 1'h0;
            end
            pwr_pkg::st_run:
            begin
                boot_start = 1'h0;
                cpu_clock_enable = 1'h1;
            end
            pwr_pkg::st_idle:
            begin
                boot_start = 1'h0;
                cpu_clock_enable = 1'h0;
            end
            pwr_pkg::st_stop:
            begin
                boot_start = 1'h0;
                cpu_clock_enable = 1'h0;
            end
            pwr_pkg::st_shut:
            begin
                boot_start = 1'h0;
                cpu_clock_enable = 1'h0;
            end
            pwr_pkg::st_wake:
            begin
                boot_start = 1'h0;
                cpu_clock_enable = 1'h0;
            end
            default:
            begin
                boot_start = 1'h0;
                cpu_clock_enable = 1'h0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Peripheral, interrupt and supply gating
    // ------------------------------------------------------------------
    always_comb
    begin
        periph_enable = 1'h0;
        int_enable = 1'h0;
        supply_off = 1'h0;
        case (state)
            pwr_pkg::st_boot:
            begin
                periph_enable = 1'h0;
                int_enable = 1'h0;
                supply_off = 1'h0;
            end
            pwr_pkg::st_run:
            begin
                periph_enable = 1'h1;
                int_enable = 1'h1;
                supply_off = 1'h0;
            end
            pwr_pkg::st_idle:
            begin
                periph_enable = 1'h1;
                int_enable = 1'h1;
                supply_off = 1'h0;
            end
            pwr_pkg::st_stop:
            begin
                periph_enable = 1'h0;
                int_enable = 1'h0;
                supply_off = 1'h0;
            end
            pwr_pkg::st_shut:
            begin
                periph_enable = 1'h0;
                int_enable = 1'h0;
                supply_off = 1'h1;
            end
            pwr_pkg::st_wake:
            begin
                periph_enable = 1'h0;
                int_enable = 1'h0;
                supply_off = 1'h1;
            end
            default:
            begin
                periph_enable = 1'h0;
                int_enable = 1'h0;
                supply_off = 1'h0;
            end
        endcase
    end

    assign mode_state = state;

endmodule // cpu_power_mode_control

`default_nettype wire

// file: src/pwr_cfg.svh
// Constants for the processor power mode controller
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH

// ----------------------------------------------------------------------
// Power control register
// ----------------------------------------------------------------------
`define PWR_CTRL_ADDR 8'h87
`define PWR_CTRL_RESET 8'h00
`define PWR_IDLE_BIT 0
`define PWR_STOP_BIT 1
`define PWR_FLAGS_MSB 7
`define PWR_FLAGS_LSB 2
`define PWR_FLAGS_WIDTH 6
`define PWR_FLAGS_RESET 6'h00
`define PWR_SELECT_READ 2'h0
`define PWR_RDATA_IDLE 8'h00

// ----------------------------------------------------------------------
// Wake pins and synchroniser
// ----------------------------------------------------------------------
`define PWR_GPIO_COUNT 9
`define PWR_GPIO_IDLE 9'h1FF
`define PWR_SYNC_RESET 1'h1

`endif

// file: src/pwr_pkg.sv
// Types shared by the processor power mode controller
`default_nettype none

package pwr_pkg;

    // Controller states, one-hot
    typedef enum logic [5:0] {
        st_boot = 6'h01,
        st_run = 6'h02,
        st_idle = 6'h04,
        st_stop = 6'h08,
        st_shut = 6'h10,
        st_wake = 6'h20
    } pwr_state_t;

endpackage : pwr_pkg

`default_nettype wire

// file: src/pwr_reg.sv
// Power control special function register
`default_nettype none

`include "pwr_cfg.svh"

module pwr_reg
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_write,
    input wire logic sfr_read,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Mode selects towards the controller
    input wire logic idle_clear,
    output logic idle_select,
    output logic stop_select,
    output logic [`PWR_FLAGS_WIDTH-1:0] general_flags
);

    logic hit_write;

    assign sfr_hit = (sfr_addr == `PWR_CTRL_ADDR);
    assign hit_write = sfr_hit && sfr_write;

    // ------------------------------------------------------------------
    // General flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            general_flags <= `PWR_FLAGS_RESET;
        end
        else if (clk_en && hit_write)
        begin
            general_flags <= sfr_wdata[`PWR_FLAGS_MSB:`PWR_FLAGS_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Idle select, cleared by an interrupt wake
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            idle_select <= 1'h0;
        end
        else if (clk_en)
        begin
            if (hit_write && sfr_wdata[`PWR_IDLE_BIT])
            begin
                idle_select <= 1'h1;
            end
            else if (idle_clear)
            begin
                idle_select <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Stop select, only reset clears it
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stop_select <= 1'h0;
        end
        else if (clk_en && hit_write && sfr_wdata[`PWR_STOP_BIT])
        begin
            stop_select <= 1'h1;
        end
    end

    // ------------------------------------------------------------------
    // Read data, select bits always read as zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sfr_rdata <= `PWR_CTRL_RESET;
        end
        else if (clk_en)
        begin
            if (sfr_hit && sfr_read)
            begin
                sfr_rdata <= {general_flags, `PWR_SELECT_READ};
            end
            else
            begin
                sfr_rdata <= `PWR_RDATA_IDLE;
            end
        end
    end

endmodule // pwr_reg

`default_nettype wire

// file: src/pwr_sync.sv
// Three-stage pin synchroniser with agreement filter, one per bit
`default_nettype none

`include "pwr_cfg.svh"

module pwr_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Pins and settled levels
    input wire logic [`PWR_GPIO_COUNT-1:0] pin_in,
    output logic [`PWR_GPIO_COUNT-1:0] pin_level
);

    genvar i;

    generate
        for (i = 0; i < `PWR_GPIO_COUNT; i = i + 1)
        begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            logic level;

            // ----------------------------------------------------------
            // Three flops, level changes once stages two and three agree
            // ----------------------------------------------------------
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    s1 <= `PWR_SYNC_RESET;
                    s2 <= `PWR_SYNC_RESET;
                    s3 <= `PWR_SYNC_RESET;
                    level <= `PWR_SYNC_RESET;
                end
                else if (clk_en)
                begin
                    s1 <= pin_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                    begin
                        level <= s3;
                    end
                end
            end

            assign pin_level[i] = level;
        end
    endgenerate

endmodule // pwr_sync

`default_nettype wire
